// ==== hdl/udct_pkg.sv ====
// constants shared by the up/down capture timer and its edge sense
// assumes a single synchronous clock domain (clk_sys)
package udct_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int CNT_W   = 11;   // timer counter
   localparam int RTC_W   = 22;   // real-time clock snapshot and value register
   localparam int PER_W   = 8;    // period count field
   localparam int PIN_N   = 12;   // general purpose input pins
   localparam int SEL_W   = 4;    // pin select field
   localparam int CH_N    = 2;    // edge sense channels

   // ----------------------------------------------------------------
   // values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_ZERO      = 11'h000;
   localparam logic [CNT_W-1:0] CNT_ONE       = 11'h001;
   localparam logic [CNT_W-1:0] CNT_MAX       = 11'h7ff;
   localparam logic [RTC_W-1:0] VAL_ZERO      = 22'h000000;
   localparam logic [RTC_W-1:0] VAL_ONE       = 22'h000001;
   localparam logic [PER_W-1:0] PER_ZERO      = 8'h00;
   localparam logic [PER_W-1:0] PER_ONE       = 8'h01;
   localparam logic [SEL_W-1:0] SEL_FIRST     = 4'h1;  // selects pin 0
   localparam logic [SEL_W-1:0] SEL_LAST      = 4'hc;  // selects pin 11

   // channel mode and snapshot encodings
   typedef enum logic {UDCT_CAPTURE = 1'b0, UDCT_COUNTING = 1'b1} udct_mode_e;
   typedef enum logic {UDCT_SRC_TIMER = 1'b0, UDCT_SRC_RTC = 1'b1} udct_src_e;

endpackage : udct_pkg

// ==== hdl/udct_edge_if.sv ====
// carrier between the timer core and one edge sense channel
// assumes clk_sys domain on both sides
`timescale 1ns/10ps
interface udct_edge_if;
   import udct_pkg::*;
   logic [PIN_N-1:0] pins;        // raw pin levels
   logic [SEL_W-1:0] pin_sel;     // 1..12 picks pin 0..11
   logic             falling;     // 1 falling, 0 rising
   logic             edge_pulse;  // one cycle per detected edge

   modport core  (output pins, output pin_sel, output falling, input edge_pulse);
   modport sense (input pins, input pin_sel, input falling, output edge_pulse);
endinterface : udct_edge_if

// ==== hdl/udct_edge_sense.sv ====
// one edge sense channel: pin select, synchroniser, edge detect
// assumes pins arrive on clk_sys and the selection changes rarely
`timescale 1ns/10ps
module udct_edge_sense
   import udct_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // channel carrier
   udct_edge_if.sense eif
);

   logic sel_pin;
   logic sync1;
   logic sync2;
   logic prev;

   // ----------------------------------------------------------------
   // pin select: out-of-range codes pick nothing
   // ----------------------------------------------------------------
   always_comb
   begin
      sel_pin = 1'b0;
      if (eif.pin_sel >= SEL_FIRST && eif.pin_sel <= SEL_LAST)
      begin
         sel_pin = eif.pins[eif.pin_sel - SEL_FIRST];
      end
   end

   // two-stage synchroniser plus previous sample
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev  <= 1'b0;
      end
      else
      begin
         sync1 <= sel_pin;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   // edge compare on synchronised samples only
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         eif.edge_pulse <= 1'b0;
      end
      else
      begin
         eif.edge_pulse <= eif.falling ? (prev & ~sync2)
                                       : (~prev & sync2);
      end
   end

endmodule // udct_edge_sense

// ==== hdl/udct_timer.sv ====
// 11-bit up/down timer with two-channel capture / edge counting
// assumes all inputs synchronous to clk_sys; low_power_clock is sampled
//
// Notes on behaviour
// - count up or down; interrupt at limits
// - eleven bits; free run interrupts at zero
// - two channels, each sensing its own pin
// - counting mode reports timer ticks after N edges
// - counting restarts automatically for next group
// - capture stores timer count or clock snapshot
// - capture while pending discards, sets overrun
// - overrun clears together with event flag
// - both channels may share one pin
// - tick from system or low-power clock
// - separate control bits; gate and enable
// - polarity bit set means falling edge
// - mode bit 0 capture, 1 counting
// - per-channel interrupt only when enabled
// - snapshot source selects clock or count
// - pin select 1..12 maps pins 0..11
// - value register holds result at interrupt
// - writing 1 clears the channel event
// - period count plus one edges per report
`timescale 1ns/10ps
module udct_timer
   import udct_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   // timer control
   input  wire logic                  clock_source_select,
   input  wire logic                  low_power_clock,
   input  wire logic                  free_run_enable,
   input  wire logic                  timer_irq_enable,
   input  wire logic                  count_direction_down,
   input  wire logic [CNT_W-1:0]      reload_threshold,
   input  wire logic                  timer_clock_gate,
   input  wire logic                  timer_run_enable,
   // channel control
   input  wire logic [CH_N-1:0]       edge_polarity_falling,
   input  wire logic [CH_N-1:0]       channel_count_mode,
   input  wire logic [CH_N-1:0]       channel_irq_enable,
   input  wire logic [CH_N-1:0]       snapshot_source,
   input  wire logic [SEL_W-1:0]      channel_pin_select [CH_N],
   input  wire logic [PER_W-1:0]      channel_period_count [CH_N],
   input  wire logic [CH_N-1:0]       channel_event_clear,
   // external sources
   input  wire logic [PIN_N-1:0]      gpio_in,
   input  wire logic [RTC_W-1:0]      rtc_value,
   // status
   output logic [CNT_W-1:0]           timer_count,
   output logic                       timer_irq,
   output logic [CH_N-1:0]            channel_event_flag,
   output logic [CH_N-1:0]            channel_overrun_flag,
   output logic [CH_N-1:0]            channel_irq,
   output logic [RTC_W-1:0]           channel_capture_value [CH_N]
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic             lp_s1;
   logic             lp_s2;
   logic             lp_s3;
   logic             lp_rise;
   logic             running;
   logic             tick;
   logic [CNT_W-1:0] next_count;
   logic             limit_hit;
   logic [CH_N-1:0]  edge_seen;

   udct_edge_if eif0 ();
   udct_edge_if eif1 ();

   // ----------------------------------------------------------------
   // edge sense channels
   // ----------------------------------------------------------------
   // each channel gets the full pin set, so sharing a pin is free
   assign eif0.pins    = gpio_in;
   assign eif0.pin_sel = channel_pin_select[0];
   assign eif0.falling = edge_polarity_falling[0];
   assign eif1.pins    = gpio_in;
   assign eif1.pin_sel = channel_pin_select[1];
   assign eif1.falling = edge_polarity_falling[1];
   assign edge_seen    = {eif1.edge_pulse, eif0.edge_pulse};

   udct_edge_sense u_sense0
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .eif     (eif0.sense)
   );

   udct_edge_sense u_sense1
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .eif     (eif1.sense)
   );

   // ----------------------------------------------------------------
   // timer tick
   // ----------------------------------------------------------------
   // low-power clock is sampled, so it must stay well below clk_sys / 2
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         lp_s1 <= 1'b0;
         lp_s2 <= 1'b0;
         lp_s3 <= 1'b0;
      end
      else
      begin
         lp_s1 <= low_power_clock;
         lp_s2 <= lp_s1;
         lp_s3 <= lp_s2;
      end
   end

   assign lp_rise = lp_s2 & ~lp_s3;
   assign running = timer_clock_gate & timer_run_enable;
   assign tick    = running & (clock_source_select | lp_rise);

   // ----------------------------------------------------------------
   // counter step and limit detect
   // ----------------------------------------------------------------
   always_comb
   begin
      next_count = timer_count;
      limit_hit  = 1'b0;
      if (count_direction_down)
      begin
         // zero reached: reload from threshold
         next_count = (timer_count == CNT_ZERO) ? reload_threshold
                                                : timer_count - CNT_ONE;
         limit_hit  = (next_count == CNT_ZERO);
      end
      else if (free_run_enable)
      begin
         // free run only applies counting up; counting down ignores it
         next_count = timer_count + CNT_ONE;
         limit_hit  = (next_count == CNT_ZERO);
      end
      else
      begin
         next_count = (timer_count >= reload_threshold) ? CNT_ZERO
                                                        : timer_count + CNT_ONE;
         limit_hit  = (next_count == reload_threshold);
      end
   end

   // counter register; disabling parks it at its start value
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         timer_count <= CNT_ZERO;
      end
      else if (!running)
      begin
         timer_count <= count_direction_down ? reload_threshold : CNT_ZERO;
      end
      else if (tick)
      begin
         timer_count <= next_count;
      end
   end

   // timer interrupt pulse
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         timer_irq <= 1'b0;
      end
      else
      begin
         timer_irq <= tick & limit_hit & timer_irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // channel logic
   // ----------------------------------------------------------------
   for (genvar c = 0; c < CH_N; c++)
   begin : g_ch
      logic [RTC_W-1:0] cyc_cnt;
      logic [PER_W-1:0] edge_cnt;
      logic             counting;
      logic             report;
      logic             capture;
      logic             store;
      logic [RTC_W-1:0] snapshot;

      assign counting = (channel_count_mode[c] == UDCT_COUNTING);
      // the edge that makes period count plus one reports
      assign report   = edge_seen[c] & counting
                        & (edge_cnt == channel_period_count[c]);
      assign capture  = edge_seen[c] & ~counting;
      assign store    = report | capture;
      assign snapshot = (snapshot_source[c] == UDCT_SRC_RTC) ? rtc_value
                        : {{(RTC_W-CNT_W){1'b0}}, timer_count};

      // timer ticks since start or since the last report
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst || !running || !counting)
         begin
            cyc_cnt <= VAL_ZERO;
         end
         else if (report)
         begin
            cyc_cnt <= tick ? VAL_ONE : VAL_ZERO;
         end
         else if (tick)
         begin
            cyc_cnt <= cyc_cnt + VAL_ONE;
         end
      end

      // edges seen in the current group
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst || !running || !counting)
         begin
            edge_cnt <= PER_ZERO;
         end
         else if (report)
         begin
            edge_cnt <= PER_ZERO;
         end
         else if (edge_seen[c])
         begin
            edge_cnt <= edge_cnt + PER_ONE;
         end
      end

      // value register: a pending event protects the old value
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            channel_capture_value[c] <= VAL_ZERO;
         end
         else if (store && !channel_event_flag[c])
         begin
            channel_capture_value[c] <= capture ? snapshot
                                                : cyc_cnt;
         end
      end

      // event flag: a new event beats a clear in the same cycle
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            channel_event_flag[c] <= 1'b0;
         end
         else if (store)
         begin
            channel_event_flag[c] <= 1'b1;
         end
         else if (channel_event_clear[c])
         begin
            channel_event_flag[c] <= 1'b0;
         end
      end

      // overrun flag shares the event clear
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            channel_overrun_flag[c] <= 1'b0;
         end
         else if (store && channel_event_flag[c])
         begin
            channel_overrun_flag[c] <= 1'b1;
         end
         else if (channel_event_clear[c])
         begin
            channel_overrun_flag[c] <= 1'b0;
         end
      end

      // channel interrupt level follows the flag, gated by its enable
      always_ff @(posedge clk_sys)
      begin
         if (sys_rst)
         begin
            channel_irq[c] <= 1'b0;
         end
         else
         begin
            channel_irq[c] <= channel_event_flag[c] & channel_irq_enable[c];
         end
      end

      // -------------------------------------------------------------
      // channel checks
      // -------------------------------------------------------------
      a_overrun_keeps_value: assert property (
         @(posedge clk_sys) disable iff (sys_rst)
         capture && channel_event_flag[c]
         |=> channel_overrun_flag[c]
             && channel_capture_value[c] == $past(channel_capture_value[c]))
         else $error("pending capture was overwritten");

      a_clear_both_flags: assert property (
         @(posedge clk_sys) disable iff (sys_rst)
         channel_event_clear[c] && !store
         |=> !channel_event_flag[c] && !channel_overrun_flag[c])
         else $error("event clear left a flag standing");

      a_capture_source: assert property (
         @(posedge clk_sys) disable iff (sys_rst)
         capture && !channel_event_flag[c]
         |=> channel_event_flag[c] && channel_capture_value[c] == $past(snapshot))
         else $error("capture stored the wrong snapshot");

      a_irq_needs_enable: assert property (
         @(posedge clk_sys) disable iff (sys_rst)
         channel_irq[c] |-> $past(channel_irq_enable[c]) && $past(channel_event_flag[c]))
         else $error("channel interrupt without enable");

      a_group_restart: assert property (
         @(posedge clk_sys) disable iff (sys_rst)
         report && running && counting ##1 running && counting
         |-> edge_cnt == PER_ZERO)
         else $error("edge group did not restart");
   end

   // ----------------------------------------------------------------
   // timer checks
   // ----------------------------------------------------------------
   a_down_reload: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      tick && count_direction_down && timer_count == CNT_ZERO
      |=> timer_count == $past(reload_threshold))
      else $error("down count did not reload after zero");

   a_free_wrap_irq: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      tick && !count_direction_down && free_run_enable && timer_count == CNT_MAX
      |=> timer_count == CNT_ZERO && timer_irq == $past(timer_irq_enable))
      else $error("free run wrap missed zero interrupt");

   a_up_limit: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      tick && !count_direction_down && !free_run_enable
      && timer_count + CNT_ONE == reload_threshold
      |=> timer_irq == $past(timer_irq_enable) ##1 !timer_irq || $past(tick))
      else $error("threshold interrupt wrong");

   a_gate_stops: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !running [*2] |-> !timer_irq)
      else $error("timer interrupt while gated off");

endmodule // udct_timer

// ==== sim/udct_pin_model.sv ====
// pin-side model: square wave on one input pin, other pins follow the bench
// assumes clk_sys domain; half period of at least two cycles
`timescale 1ns/10ps
module udct_pin_model
   import udct_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   // generator control
   input  wire logic             gen_run,
   input  wire logic [SEL_W-1:0] gen_pin,
   input  wire logic [7:0]       gen_half,
   input  wire logic [PIN_N-1:0] manual_pins,
   // pins
   output logic      [PIN_N-1:0] gpio_in
);
   logic [7:0] half_cnt;
   logic       wave;

   // -----------------------------
   // wave generator
   // -----------------------------
   // each level held gen_half cycles so no edge is closer than two clocks
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !gen_run)
      begin
         half_cnt <= 8'h00;
         wave     <= 1'b0;
      end
      else if (half_cnt == gen_half - 8'h01)
      begin
         half_cnt <= 8'h00;
         wave     <= ~wave;
      end
      else
         half_cnt <= half_cnt + 8'h01;
   end

   // generated pin overrides the bench level only while running
   always_comb
   begin
      gpio_in = manual_pins;
      if (gen_run)
         gpio_in[gen_pin] = wave;
   end
endmodule // udct_pin_model

// ==== sim/tb_top.sv ====
// self-checking bench for the up/down capture timer
// assumes the pin model drives gpio_in; all other inputs are driven here
`timescale 1ns/10ps
module tb_top
   import udct_pkg::*;
   ;
   // -----------------------------
   // stimulus and status
   // -----------------------------
   logic             clk_sys = 1'b0;
   logic             sys_rst = 1'b1;
   logic             clock_source_select = 1'b1;
   logic             low_power_clock = 1'b0;
   logic             free_run_enable = 1'b0;
   logic             timer_irq_enable = 1'b0;
   logic             count_direction_down = 1'b0;
   logic [CNT_W-1:0] reload_threshold = CNT_ZERO;
   logic             timer_clock_gate = 1'b0;
   logic             timer_run_enable = 1'b0;
   logic [CH_N-1:0]  edge_polarity_falling = '0;
   logic [CH_N-1:0]  channel_count_mode = '0;
   logic [CH_N-1:0]  channel_irq_enable = '0;
   logic [CH_N-1:0]  snapshot_source = '0;
   logic [CH_N-1:0]  channel_event_clear = '0;
   logic [SEL_W-1:0] channel_pin_select [CH_N] = '{SEL_FIRST, SEL_FIRST};
   logic [PER_W-1:0] channel_period_count [CH_N] = '{PER_ZERO, PER_ZERO};
   logic [RTC_W-1:0] rtc_value = VAL_ZERO;
   logic [PIN_N-1:0] manual_pins = '0;
   logic             gen_run = 1'b0;
   logic [SEL_W-1:0] gen_pin = 4'h0;
   logic [7:0]       gen_half = 8'h04;
   logic [1:0]       lp_div = 2'h0;
   logic [PIN_N-1:0] gpio_in;
   logic [CNT_W-1:0] timer_count;
   logic             timer_irq;
   logic [CH_N-1:0]  channel_event_flag;
   logic [CH_N-1:0]  channel_overrun_flag;
   logic [CH_N-1:0]  channel_irq;
   logic [RTC_W-1:0] channel_capture_value [CH_N];
   logic [RTC_W-1:0] exp_v;
   logic [CNT_W-1:0] r;
   logic [PER_W-1:0] n;
   logic [7:0]       h;
   logic             pol;
   logic             src;
   int               failures = 0;
   int               n_checks = 0;
   int               gap;
   int               k;
   int               pin;

   udct_timer dut_u (.clk_sys, .sys_rst, .clock_source_select, .low_power_clock,
      .free_run_enable, .timer_irq_enable, .count_direction_down, .reload_threshold,
      .timer_clock_gate, .timer_run_enable, .edge_polarity_falling, .channel_count_mode,
      .channel_irq_enable, .snapshot_source, .channel_pin_select, .channel_period_count,
      .channel_event_clear, .gpio_in, .rtc_value, .timer_count, .timer_irq,
      .channel_event_flag, .channel_overrun_flag, .channel_irq, .channel_capture_value);

   udct_pin_model pm_u (.clk_sys, .sys_rst, .gen_run, .gen_pin, .gen_half, .manual_pins,
      .gpio_in);

   // -----------------------------
   // clocks
   // -----------------------------
   initial
   begin
      forever #20 clk_sys = ~clk_sys;
   end

   // slow clock at an eighth of clk_sys, well under the sampler's limit
   always @(posedge clk_sys)
   begin
      lp_div <= lp_div + 2'h1;
      if (lp_div == 2'h3)
         low_power_clock <= ~low_power_clock;
   end

   // -----------------------------
   // expectations and helpers
   // -----------------------------
   function automatic int tmr_period(input logic fr, input logic [CNT_W-1:0] rl,
                                     input logic lp);
      tmr_period = (fr ? 2048 : int'(rl) + 1) * (lp ? 8 : 1);
   endfunction

   function automatic logic [RTC_W-1:0] cnt_value(input logic [PER_W-1:0] np,
                                                   input logic [7:0] hp);
      cnt_value = RTC_W'((int'(np) + 1) * 2 * int'(hp));
   endfunction

   function automatic logic [RTC_W-1:0] snap(input logic s, input logic [CNT_W-1:0] rl,
                                              input logic [RTC_W-1:0] rt);
      snap = s ? rt : RTC_W'(rl);
   endfunction

   task automatic chk(input logic [RTC_W-1:0] got, input logic [RTC_W-1:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge clk_sys);
   endtask

   // cycles between two timer interrupt pulses, bounded
   task automatic irq_gap(output int g);
      for (int i = 0; i < 9000 && timer_irq !== 1'b1; i++)
         @(negedge clk_sys);
      @(negedge clk_sys);
      g = 1;
      while (timer_irq !== 1'b1 && g < 9000)
      begin
         @(negedge clk_sys);
         g++;
      end
   endtask

   task automatic wait_flag(input int ch);
      for (int i = 0; i < 600 && channel_event_flag[ch] !== 1'b1; i++)
         @(negedge clk_sys);
   endtask

   // flag lands four clocks after the pin moves; six gives margin
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge clk_sys);
      manual_pins[idx] <= lvl;
      cyc(6);
   endtask

   task automatic clear(input logic [CH_N-1:0] m);
      @(posedge clk_sys);
      channel_event_clear <= m;
      @(posedge clk_sys);
      channel_event_clear <= '0;
      cyc(2);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard: the whole run needs well under 60000 cycles
   initial
   begin
      #2400000;
      failures++;
      end_of_test();
   end

   // -----------------------------
   // main sequence
   // -----------------------------
   initial
   begin
      void'($urandom(89677));
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // timer modes: 0 up, 1 down, 2 free run up, 3 up on the slow clock
      for (int m = 0; m < 4; m++)
      begin
         r = CNT_W'(2 + $urandom % 15);
         @(posedge clk_sys);
         reload_threshold     <= r;
         count_direction_down <= (m == 1);
         free_run_enable      <= (m == 2);
         clock_source_select  <= (m != 3);
         timer_irq_enable     <= 1'b1;
         timer_clock_gate     <= 1'b1;
         timer_run_enable     <= 1'b1;
         irq_gap(gap);
         irq_gap(gap);
         chk(RTC_W'(gap), RTC_W'(tmr_period(m == 2, r, m == 3)));
         $display("timer mode %0d finished", m);
      end
      // masked interrupt, then gate closed parks the count
      @(posedge clk_sys);
      free_run_enable     <= 1'b0;
      clock_source_select <= 1'b1;
      timer_irq_enable    <= 1'b0;
      k = 0;
      repeat (40)
      begin
         @(negedge clk_sys);
         if (timer_irq !== 1'b0)
            k++;
      end
      chk(RTC_W'(k), VAL_ZERO);
      @(posedge clk_sys);
      timer_clock_gate <= 1'b0;
      cyc(4);
      chk(RTC_W'(timer_count), RTC_W'(CNT_ZERO));
      $display("gating finished");
      // capture on both channels sharing one pin, every polarity and source
      for (int c = 0; c < 4; c++)
      begin
         pin = $urandom % PIN_N;
         pol = c[0];
         src = c[1];
         @(posedge clk_sys);
         timer_clock_gate      <= 1'b1;
         timer_run_enable      <= 1'b0;
         count_direction_down  <= 1'b1;
         edge_polarity_falling <= {2{pol}};
         channel_count_mode    <= '0;
         snapshot_source       <= {2{src}};
         channel_irq_enable    <= 2'($urandom);
         channel_pin_select    <= '{SEL_W'(pin + 1), SEL_W'(pin + 1)};
         rtc_value             <= RTC_W'($urandom);
         reload_threshold      <= CNT_W'($urandom);
         set_pin(pin, ~pol);
         clear(2'b11);
         set_pin(pin, pol);
         chk(RTC_W'(channel_event_flag), VAL_ZERO);
         set_pin(pin, ~pol);
         exp_v = snap(src, reload_threshold, rtc_value);
         chk(RTC_W'(channel_event_flag), RTC_W'(2'b11));
         chk(channel_capture_value[0], exp_v);
         chk(channel_capture_value[1], exp_v);
         chk(RTC_W'(channel_irq), RTC_W'(channel_irq_enable));
         @(posedge clk_sys);
         rtc_value        <= ~rtc_value;
         reload_threshold <= ~reload_threshold;
         set_pin(pin, pol);
         set_pin(pin, ~pol);
         chk(RTC_W'(channel_overrun_flag), RTC_W'(2'b11));
         chk(channel_capture_value[0], exp_v);
         clear(2'b01);
         chk(RTC_W'({channel_overrun_flag, channel_event_flag}), RTC_W'(4'ha));
         clear(2'b10);
         $display("capture case %0d finished", c);
      end
      // counting mode: cycles per group of edges, repeated automatically
      n = PER_W'(1 + $urandom % 4);
      // four cycles at least: at three the first group's count equals a full group's
      h = 8'(4 + $urandom % 4);
      @(posedge clk_sys);
      manual_pins          <= '0;
      count_direction_down <= 1'b0;
      free_run_enable      <= 1'b1;
      timer_run_enable     <= 1'b1;
      channel_count_mode   <= 2'b11;
      edge_polarity_falling <= 2'b00;
      channel_period_count <= '{n, n};
      gen_pin              <= SEL_W'(pin);
      gen_half             <= h;
      gen_run              <= 1'b1;
      wait_flag(0);
      clear(2'b11);
      wait_flag(0);
      chk(channel_capture_value[0], cnt_value(n, h));
      chk(channel_capture_value[1], cnt_value(n, h));
      // a code past the last pin selects nothing, so channel 1 stays quiet
      @(posedge clk_sys);
      channel_pin_select[1] <= SEL_W'(PIN_N + 1);
      cyc(6);
      clear(2'b11);
      wait_flag(0);
      chk(RTC_W'(channel_event_flag), RTC_W'(2'b01));
      $display("counting finished");
      end_of_test();
   end
endmodule // tb_top
